// File: hdl/addr_calc.sv
// Purpose: Effective address and post-update value for one mode
// Assumes: Pure combinational, pointers stable while in use
// Notes:   All sums wrap at 16 bits
`timescale 1ns/100ps
`include "operand_addr_defines.svh"
module addr_calc
    import operand_addr_pkg::*;
(
    input  wire ptrs_s        ptrs,
    input  wire amode_e       amode,
    input  wire logic [7:0]   disp,
    input  wire logic [7:0]   acc,
    input  wire logic [7:0]   breg,
    input  wire logic [15:0]  ext_accum,
    output wire logic [15:0]  ea,
    output wire logic         upd_two,
    output wire logic         upd_three,
    output wire logic [15:0]  upd_val
);

    // Which base pair a mode uses
    function automatic logic uses_two(amode_e m);
        return m inside {AM_P2, AM_P2_INC, AM_P2_DEC, AM_P2_INC2,
                         AM_P2_DISP};
    endfunction

    // Unsigned offsets, zero extended, never sign extended
    function automatic logic [15:0] offset_of(amode_e m, logic [7:0] d,
            logic [7:0] a, logic [7:0] b, logic [15:0] e);
        unique case (m)
            AM_P2_DISP, AM_P3_DISP: return {8'h00, d};
            AM_P3_A:                return {8'h00, a};
            AM_P3_B:                return {8'h00, b};
            AM_P3_EA:               return e;
            default:                return 16'h0000;
        endcase
    endfunction

    // Post-access step of the auto modes
    function automatic logic [15:0] step_of(amode_e m);
        unique case (m)
            AM_P2_INC, AM_P3_INC:   return `STEP_ONE;
            AM_P2_DEC, AM_P3_DEC:   return `STEP_MINUS;
            AM_P2_INC2, AM_P3_INC2: return `STEP_TWO;
            default:                return 16'h0000;
        endcase
    endfunction

    wire logic [15:0] base;
    wire logic        stepped;

    // Base select and address sum
    assign base = (amode == AM_P1) ? ptrs.pair_one :
                  uses_two(amode)  ? ptrs.pair_two : ptrs.pair_three;
    assign ea = base + offset_of(amode, disp, acc, breg, ext_accum);
    assign stepped = (step_of(amode) != 16'h0000);
    // Plain, base and index modes leave the pair alone
    assign upd_two   = stepped & uses_two(amode);
    assign upd_three = stepped & ~uses_two(amode);
    assign upd_val   = base + step_of(amode);

endmodule

// File: hdl/operand_addr_defines.svh
// Purpose: Constants for the operand address generator
// Assumes: 16-bit pointers, byte-wide memory bus
// Notes:   Included by the design modules by bare name
`ifndef OPERAND_ADDR_DEFINES_SVH
`define OPERAND_ADDR_DEFINES_SVH

// Reset value of every pointer register
`define PTR_RESET   16'h0000
// Pointer steps, all taken modulo 65536
`define STEP_ONE    16'h0001
`define STEP_TWO    16'h0002
`define STEP_THREE  16'h0003
`define STEP_MINUS  16'hFFFF
// Last byte index of a transfer
`define LAST_SINGLE 2'h0
`define LAST_PAIR   2'h1
`define LAST_TRAP   2'h2

`endif

// File: hdl/operand_addr_gen.sv
// Purpose: Operand address generation and pointer updates
// Assumes: Single clock, memory bus answers with mem_ack, rstn sync
// Notes:   Pointers change only after the last byte is acknowledged
`timescale 1ns/100ps
`include "operand_addr_defines.svh"
module operand_addr_gen
    import operand_addr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         start,
    input  wire cmd_s         cmd,
    output wire logic         busy,
    output wire logic         done,
    output wire logic [15:0]  result,
    input  wire logic         ptr_wr_en,
    input  wire ptr_id_e      ptr_wr_sel,
    input  wire logic [15:0]  ptr_wr_data,
    output wire ptrs_s        ptrs,
    output wire logic         mem_req,
    output wire mem_s         mem,
    input  wire logic         mem_ack,
    input  wire logic [7:0]   mem_rdata
);

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_FINISH}
        state_e;

    state_e       state_r;
    cmd_s         cmd_r;
    ptrs_s        ptrs_r;
    ptrs_s        snap_r;
    logic [1:0]   idx_r;
    logic [7:0]   lo_r;
    logic [7:0]   hi_r;
    logic         req_r;
    mem_s         mem_r;
    logic         done_r;
    logic [15:0]  result_r;

    wire logic [15:0] ea;
    wire logic        upd_two;
    wire logic        upd_three;
    wire logic [15:0] upd_val;

    // Mode arithmetic on the live pointers, held steady while busy
    addr_calc u_calc (
        .ptrs      (ptrs_r),
        .amode     (cmd_r.amode),
        .disp      (cmd_r.disp),
        .acc       (cmd_r.acc),
        .breg      (cmd_r.breg),
        .ext_accum (cmd_r.ext_accum),
        .ea        (ea),
        .upd_two   (upd_two),
        .upd_three (upd_three),
        .upd_val   (upd_val)
    );

    // Last byte index of each operation
    function automatic logic [1:0] last_of(op_e op);
        unique case (op)
            OP_LOAD_WIDE, OP_STORE_WIDE, OP_BLOCK, OP_POP, OP_RET,
            OP_PUSH, OP_CALL:  return `LAST_PAIR;
            OP_TRAP:           return `LAST_TRAP;
            default:           return `LAST_SINGLE;
        endcase
    endfunction

    wire logic [15:0] idx_w;
    wire logic        is_pop;
    wire logic        is_push;
    wire logic        last_byte;
    wire logic [15:0] byte_addr;
    wire logic        byte_we;
    wire logic [7:0]  byte_wdata;
    wire logic [7:0]  push_byte;

    assign idx_w     = {14'h0000, idx_r};
    assign is_pop    = cmd_r.op inside {OP_POP, OP_RET};
    assign is_push   = cmd_r.op inside {OP_PUSH, OP_CALL, OP_TRAP};
    assign last_byte = (idx_r == last_of(cmd_r.op));

    // Address of the current byte
    assign byte_addr =
        (cmd_r.op == OP_BLOCK) ?
            ((idx_r == 2'h0) ? ptrs_r.pair_three : ptrs_r.pair_two) :
        is_pop  ? ptrs_r.sp + idx_w :
        is_push ? ptrs_r.sp - idx_w - `STEP_ONE :
        ea + idx_w;

    // Writes: stores, pushes and the second half of a block move
    assign byte_we = (cmd_r.op inside {OP_STORE_ACC, OP_STORE_WIDE}) ||
                     is_push ||
                     (cmd_r.op == OP_BLOCK && idx_r == 2'h1);

    // Stack order is high then low; a trap stores status first, then high, then low
    assign push_byte = (cmd_r.op == OP_TRAP) ?
        ((idx_r == 2'h0) ? cmd_r.prog_status_word :
         (idx_r == 2'h1) ? cmd_r.push_data[15:8] : cmd_r.push_data[7:0]) :
        ((idx_r == 2'h0) ? cmd_r.push_data[15:8] : cmd_r.push_data[7:0]);

    assign byte_wdata =
        (cmd_r.op == OP_STORE_ACC)  ? cmd_r.acc :
        (cmd_r.op == OP_STORE_WIDE) ?
            ((idx_r == 2'h0) ? cmd_r.ext_accum[7:0]
                             : cmd_r.ext_accum[15:8]) :
        (cmd_r.op == OP_BLOCK)      ? lo_r :
        push_byte;

    // Result of the finished operation
    wire logic [15:0] result_nxt;
    wire logic [7:0]  add_sum;
    assign add_sum    = cmd_r.acc + lo_r;
    assign result_nxt =
        (cmd_r.op == OP_LOAD_ACC) ? {8'h00, lo_r} :
        (cmd_r.op == OP_ADD_ACC)  ? {8'h00, add_sum} :
        {hi_r, lo_r};

    // Pointer values after the operation; never before its last access
    ptrs_s ptrs_nxt;
    always_comb begin
        ptrs_nxt = ptrs_r;
        if (state_r == ST_FINISH) begin
            if (cmd_r.op == OP_BLOCK) begin
                ptrs_nxt.pair_two   = ptrs_r.pair_two + `STEP_ONE;
                ptrs_nxt.pair_three = ptrs_r.pair_three + `STEP_ONE;
            end else if (is_pop) begin
                ptrs_nxt.sp = ptrs_r.sp + `STEP_TWO;
            end else if (cmd_r.op == OP_TRAP) begin
                ptrs_nxt.sp = ptrs_r.sp - `STEP_THREE;
            end else if (is_push) begin
                ptrs_nxt.sp = ptrs_r.sp - `STEP_TWO;
            end else if (upd_two) begin
                ptrs_nxt.pair_two = upd_val;
            end else if (upd_three) begin
                ptrs_nxt.pair_three = upd_val;
            end
        end else if (state_r == ST_IDLE && ptr_wr_en) begin
            unique case (ptr_wr_sel)
                ID_P1: ptrs_nxt.pair_one   = ptr_wr_data;
                ID_P2: ptrs_nxt.pair_two   = ptr_wr_data;
                ID_P3: ptrs_nxt.pair_three = ptr_wr_data;
                ID_SP: ptrs_nxt.sp         = ptr_wr_data;
            endcase
        end
    end

    // Pointer file; pointer loads are ignored while busy
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ptrs_r <= '{default: `PTR_RESET};
        end else begin
            ptrs_r <= ptrs_nxt;
        end
    end

    // Sequencer: one byte access per issue/wait pair
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r  <= ST_IDLE;
            cmd_r    <= '0;
            snap_r   <= '0;
            idx_r    <= 2'h0;
            lo_r     <= 8'h00;
            hi_r     <= 8'h00;
            req_r    <= 1'b0;
            mem_r    <= '0;
            done_r   <= 1'b0;
            result_r <= 16'h0000;
        end else begin
            done_r <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        cmd_r   <= cmd;
                        snap_r  <= ptrs_r;
                        idx_r   <= 2'h0;
                        state_r <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    mem_r   <= '{we: byte_we, addr: byte_addr,
                                 wdata: byte_wdata};
                    req_r   <= 1'b1;
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (mem_ack) begin
                        req_r <= 1'b0;
                        if (idx_r == 2'h0) lo_r <= mem_rdata;
                        if (idx_r == 2'h1) hi_r <= mem_rdata;
                        if (last_byte) begin
                            state_r <= ST_FINISH;
                        end else begin
                            idx_r   <= idx_r + 2'h1;
                            state_r <= ST_ISSUE;
                        end
                    end
                end
                ST_FINISH: begin
                    result_r <= result_nxt;
                    done_r   <= 1'b1;
                    state_r  <= ST_IDLE;
                end
            endcase
        end
    end

    assign busy    = (state_r != ST_IDLE);
    assign done    = done_r;
    assign result  = result_r;
    assign ptrs    = ptrs_r;
    assign mem_req = req_r;
    assign mem     = mem_r;

    // Checks on pointer updates and access addresses
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    wire logic first_req;
    assign first_req = req_r && idx_r == 2'h0;

    AST_P1_KEPT: assert property (
        done_r && cmd_r.amode == AM_P1 && cmd_r.op == OP_LOAD_ACC
        |-> ptrs_r.pair_one == snap_r.pair_one)
        else $error("pair_one changed by indirect load");
    AST_INC_ONE: assert property (
        done_r && cmd_r.op == OP_STORE_ACC && cmd_r.amode == AM_P2_INC
        |-> ptrs_r.pair_two == snap_r.pair_two + `STEP_ONE)
        else $error("pair_two not advanced by one");
    AST_DEC_ONE: assert property (
        done_r && cmd_r.op == OP_ADD_ACC && cmd_r.amode == AM_P3_DEC
        |-> ptrs_r.pair_three == snap_r.pair_three - `STEP_ONE)
        else $error("pair_three not decremented by one");
    AST_INC_TWO: assert property (
        done_r && cmd_r.amode == AM_P3_INC2 && cmd_r.op != OP_BLOCK
        && !is_pop && !is_push
        |-> ptrs_r.pair_three == snap_r.pair_three + `STEP_TWO)
        else $error("pair_three not advanced by two");
    AST_BLOCK_BOTH: assert property (
        done_r && cmd_r.op == OP_BLOCK
        |-> ptrs_r.pair_two == snap_r.pair_two + `STEP_ONE
            && ptrs_r.pair_three == snap_r.pair_three + `STEP_ONE)
        else $error("block move pointers wrong");
    AST_POP_SP: assert property (
        done_r && is_pop |-> ptrs_r.sp == snap_r.sp + `STEP_TWO)
        else $error("stack pointer not raised by two");
    AST_TRAP_SP: assert property (
        done_r && cmd_r.op == OP_TRAP
        |-> ptrs_r.sp == snap_r.sp - `STEP_THREE)
        else $error("trap stack pointer wrong");
    AST_TRAP_PSW: assert property (
        $rose(req_r) && idx_r == 2'h0 && cmd_r.op == OP_TRAP
        |-> mem_r.we && mem_r.addr == snap_r.sp - `STEP_ONE
            && mem_r.wdata == cmd_r.prog_status_word)
        else $error("status word not stored below stack pointer");
    AST_DISP_ADDR: assert property (
        first_req && cmd_r.amode == AM_P3_DISP && cmd_r.op != OP_BLOCK
        && !is_pop && !is_push
        |-> mem_r.addr == snap_r.pair_three + {8'h00, cmd_r.disp})
        else $error("displacement address wrong");
    AST_INDEX_B: assert property (
        first_req && cmd_r.amode == AM_P3_B && cmd_r.op == OP_LOAD_ACC
        |-> mem_r.addr == snap_r.pair_three + {8'h00, cmd_r.breg}
            ##1 (state_r != ST_IDLE)[*1])
        else $error("index address wrong");
    AST_OLD_VALUE: assert property (
        first_req && cmd_r.amode == AM_P2_INC && cmd_r.op != OP_BLOCK
        && !is_pop && !is_push
        |-> mem_r.addr == snap_r.pair_two
            && ptrs_r.pair_two == snap_r.pair_two)
        else $error("pointer moved before its access");
    AST_DISP_KEPT: assert property (
        done_r && cmd_r.amode == AM_P3_DISP && cmd_r.op == OP_STORE_ACC
        |-> ptrs_r.pair_three == snap_r.pair_three)
        else $error("pair_three moved by displacement store");

endmodule

// File: hdl/operand_addr_pkg.sv
// Purpose: Types shared by the operand address generator files
// Assumes: Used together with operand_addr_defines.svh
// Notes:   Mode and operation codes are internal, not opcode bits
package operand_addr_pkg;

    typedef enum logic [3:0] {
        OP_LOAD_ACC, OP_STORE_ACC, OP_ADD_ACC, OP_LOAD_WIDE,
        OP_STORE_WIDE, OP_BLOCK, OP_POP, OP_RET, OP_PUSH, OP_CALL,
        OP_TRAP
    } op_e;

    typedef enum logic [3:0] {
        AM_P1, AM_P2, AM_P3, AM_P2_INC, AM_P3_INC, AM_P2_DEC,
        AM_P3_DEC, AM_P2_INC2, AM_P3_INC2, AM_P2_DISP, AM_P3_DISP,
        AM_P3_A, AM_P3_B, AM_P3_EA
    } amode_e;

    typedef enum logic [1:0] {
        ID_P1, ID_P2, ID_P3, ID_SP
    } ptr_id_e;

    typedef struct packed {
        op_e         op;
        amode_e      amode;
        logic [7:0]  disp;
        logic [7:0]  acc;
        logic [7:0]  breg;
        logic [7:0]  prog_status_word;
        logic [15:0] ext_accum;
        logic [15:0] push_data;
    } cmd_s;

    typedef struct packed {
        logic [15:0] pair_one;
        logic [15:0] pair_two;
        logic [15:0] pair_three;
        logic [15:0] sp;
    } ptrs_s;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_s;

endpackage

// File: test/mem_model.sv
// Purpose: Byte-wide program and data memory on the far side of the bus
// Assumes: One request at a time, request held until acknowledged
// Notes:   Read data toggles outside a read acknowledge, so stale data is seen
`timescale 1ns/100ps
module mem_model
    import operand_addr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        mem_req,
    input  wire mem_s        mem,
    input  wire logic [3:0]  wait_cyc,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata
);
    logic [7:0] ram [0:65535];
    logic [3:0] cnt_r;
    logic       served_r;

    // One acknowledge per request, after wait_cyc idle cycles
    // Plain always, since the bench preloads the array by hierarchy
    always @(posedge clk) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata; // No hold once the byte is taken
        if (!rstn) begin
            cnt_r    <= 4'h0;
            served_r <= 1'b0;
        end else if (!mem_req) begin
            cnt_r    <= 4'h0;
            served_r <= 1'b0;
        end else if (!served_r) begin
            if (cnt_r == wait_cyc) begin
                mem_ack  <= 1'b1;
                served_r <= 1'b1;
                if (mem.we)
                    ram[mem.addr] <= mem.wdata;
                else
                    mem_rdata <= ram[mem.addr];
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// File: test/testbench.sv
// Purpose: Self-checking bench for the operand address generator
// Assumes: Memory model answers every request, delay zero except in the block move scenario
// Notes:   Every acknowledged byte is logged; all but the first byte of the wide load are compared in order
`timescale 1ns/100ps
module testbench;
    import operand_addr_pkg::*;
    logic        clk, rstn, start, busy, done, ptr_wr_en;
    logic        mem_req, mem_ack;
    cmd_s        cmd;
    ptr_id_e     ptr_wr_sel;
    logic [15:0] ptr_wr_data, result;
    ptrs_s       ptrs;
    mem_s        mem;
    logic [7:0]  mem_rdata;
    logic [3:0]  wait_cyc;
    logic [24:0] log_q [$];
    int          error_cnt, samples_checked;

    initial clk = 1'b0;
    always #10 clk = ~clk;

    operand_addr_gen operand_addr_gen_inst (.clk(clk), .rstn(rstn),
        .start(start), .cmd(cmd), .busy(busy), .done(done),
        .result(result), .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel),
        .ptr_wr_data(ptr_wr_data), .ptrs(ptrs), .mem_req(mem_req),
        .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    mem_model mem_model_inst (.clk(clk), .rstn(rstn), .mem_req(mem_req),
        .mem(mem), .wait_cyc(wait_cyc), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    // Log each byte at the edge that takes its acknowledge
    always @(posedge clk)
        if (mem_req && mem_ack)
            log_q.push_back(mem);

    task automatic report_and_stop;
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read data is not known by the log, so only we and addr count there
    task automatic acc(input int i, input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        logic [24:0] s;
        s = log_q[i];
        if (!w)
            s[7:0] = d;
        check(s, {w, a, d});
    endtask

    task automatic set_ptr(input ptr_id_e id, input logic [15:0] v);
        @(negedge clk);
        ptr_wr_en   = 1'b1;
        ptr_wr_sel  = id;
        ptr_wr_data = v;
        @(negedge clk);
        ptr_wr_en   = 1'b0;
    endtask

    // One command, returns in the cycle that shows done
    task automatic run(input op_e o, input amode_e m, input logic [7:0] d,
                       input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] p, input logic [15:0] e,
                       input logic [15:0] q);
        int n;
        log_q.delete();
        @(negedge clk);
        start = 1'b1;
        cmd   = '{o, m, d, a, b, p, e, q};
        @(negedge clk);
        start = 1'b0;
        check(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check(busy, 1'b0);
        if (n == 100)
            check(25'h0, 25'h1);
    endtask

    task automatic t_load_one;
        set_ptr(ID_P1, 16'h1234);
        mem_model_inst.ram[16'h1234] = 8'h5A;
        run(OP_LOAD_ACC, AM_P1, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h1234, 8'h5A);
        check(result, 16'h005A);
        check(ptrs.pair_one, 16'h1234);
    endtask

    task automatic t_inc;
        set_ptr(ID_P2, 16'hFFFF);
        run(OP_STORE_ACC, AM_P2_INC, 8'h00, 8'hC3, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b1, 16'hFFFF, 8'hC3);
        check(ptrs.pair_two, 16'h0000);
        set_ptr(ID_P3, 16'h0200);
        mem_model_inst.ram[16'h0200] = 8'h66;
        run(OP_LOAD_ACC, AM_P3_INC, 8'h00, 8'h00, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h0200, 8'h66);
        check(result, 16'h0066);
        check(ptrs.pair_three, 16'h0201);
    endtask

    // Slow memory here, so the old pointers must hold through the waits
    task automatic t_block;
        wait_cyc = 4'h3;
        set_ptr(ID_P3, 16'h2000);
        set_ptr(ID_P2, 16'h3000);
        mem_model_inst.ram[16'h2000] = 8'h77;
        run(OP_BLOCK, AM_P1, 8'h00, 8'h00, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h2000, 8'h77);
        acc(1, 1'b1, 16'h3000, 8'h77);
        check(log_q.size(), 2);
        check(ptrs.pair_three, 16'h2001);
        check(ptrs.pair_two, 16'h3001);
        wait_cyc = 4'h0;
    endtask

    task automatic t_unstack;
        op_e ops [2];
        ops = '{OP_POP, OP_RET};
        mem_model_inst.ram[16'h0100] = 8'h34;
        mem_model_inst.ram[16'h0101] = 8'h12;
        foreach (ops[i]) begin
            set_ptr(ID_SP, 16'h0100);
            run(ops[i], AM_P1, 8'h00, 8'h00, 8'h0, 8'h0, 16'h0, 16'h0);
            acc(0, 1'b0, 16'h0100, 8'h34);
            acc(1, 1'b0, 16'h0101, 8'h12);
            check(result, 16'h1234);
            check(ptrs.sp, 16'h0102);
        end
    endtask

    task automatic t_stack;
        op_e ops [2];
        ops = '{OP_PUSH, OP_CALL};
        foreach (ops[i]) begin
            set_ptr(ID_SP, 16'h0010);
            run(ops[i], AM_P1, 8'h00, 8'h00, 8'h0, 8'h0, 16'h0, 16'hABCD);
            acc(0, 1'b1, 16'h000F, 8'hAB);
            acc(1, 1'b1, 16'h000E, 8'hCD);
            check(ptrs.sp, 16'h000E);
        end
        set_ptr(ID_SP, 16'h0002);
        run(OP_TRAP, AM_P1, 8'h00, 8'h00, 8'h0, 8'h5E, 16'h0, 16'hABCD);
        acc(0, 1'b1, 16'h0001, 8'h5E);
        acc(1, 1'b1, 16'h0000, 8'hAB);
        acc(2, 1'b1, 16'hFFFF, 8'hCD);
        check(ptrs.sp, 16'hFFFF);
    endtask

    task automatic t_dec;
        set_ptr(ID_P3, 16'h0000);
        mem_model_inst.ram[16'h0000] = 8'h20;
        run(OP_ADD_ACC, AM_P3_DEC, 8'h00, 8'hF0, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h0000, 8'h20);
        check(result, 16'h0010);
        check(ptrs.pair_three, 16'hFFFF);
        set_ptr(ID_P2, 16'h0005);
        mem_model_inst.ram[16'h0005] = 8'h44;
        run(OP_LOAD_ACC, AM_P2_DEC, 8'h00, 8'h00, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h0005, 8'h44);
        check(ptrs.pair_two, 16'h0004);
    endtask

    task automatic t_wide;
        set_ptr(ID_P3, 16'hFFFF);
        run(OP_STORE_WIDE, AM_P3_INC2, 8'h0, 8'h0, 8'h0, 8'h0,
            16'hBEEF, 16'h0);
        acc(0, 1'b1, 16'hFFFF, 8'hEF);
        acc(1, 1'b1, 16'h0000, 8'hBE);
        check(ptrs.pair_three, 16'h0001);
        set_ptr(ID_P2, 16'h0400);
        mem_model_inst.ram[16'h0400] = 8'h11;
        mem_model_inst.ram[16'h0401] = 8'h22;
        run(OP_LOAD_WIDE, AM_P2_INC2, 8'h0, 8'h0, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(1, 1'b0, 16'h0401, 8'h22);
        check(result, 16'h2211);
        check(ptrs.pair_two, 16'h0402);
    endtask

    task automatic t_base;
        set_ptr(ID_P3, 16'hFFF8);
        run(OP_STORE_ACC, AM_P3_DISP, 8'h10, 8'h99, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b1, 16'h0008, 8'h99);
        check(ptrs.pair_three, 16'hFFF8);
        set_ptr(ID_P2, 16'h0100);
        mem_model_inst.ram[16'h01FF] = 8'h3C;
        run(OP_LOAD_ACC, AM_P2_DISP, 8'hFF, 8'h00, 8'h0, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h01FF, 8'h3C);
        check(result, 16'h003C);
    endtask

    task automatic t_index;
        set_ptr(ID_P3, 16'h1000);
        mem_model_inst.ram[16'h1080] = 8'h5D;
        mem_model_inst.ram[16'h10FF] = 8'h00;
        mem_model_inst.ram[16'h9001] = 8'h00;
        run(OP_LOAD_ACC, AM_P3_B, 8'h00, 8'h00, 8'h80, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h1080, 8'h5D);
        check(result, 16'h005D);
        run(OP_LOAD_ACC, AM_P3_A, 8'h00, 8'hFF, 8'h00, 8'h0, 16'h0, 16'h0);
        acc(0, 1'b0, 16'h10FF, 8'h00);
        run(OP_LOAD_ACC, AM_P3_EA, 8'h0, 8'h0, 8'h0, 8'h0, 16'h8001, 16'h0);
        acc(0, 1'b0, 16'h9001, 8'h00);
        check(ptrs.pair_three, 16'h1000);
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        start = 1'b0;
        cmd = '0;
        ptr_wr_en = 1'b0;
        ptr_wr_sel = ID_P1;
        ptr_wr_data = 16'h0000;
        wait_cyc = 4'h0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        t_load_one();
        t_inc();
        t_block();
        t_unstack();
        t_stack();
        t_dec();
        t_wide();
        t_base();
        t_index();
        report_and_stop();
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
endmodule
